/* rtl/scg_top.sv */
// How it works
// - CRC uses x^16 + x^12 + x^5 + 1
// - Init low holds skip high, preset FFFF
// - First input fall ends skip, starts CRC
// - Serial input is active low data
// - Shift fall shifts bit, emits checkword bit
// - Byte strobe fall captures select into flop
// - Checkword flag low while check bytes sent
// - Write output is data then check bytes
// - After check bytes output stays high
// - Read pass set on shift rise, no error
// - Pass holds while input high, no init
// - Second pass output is the complement
// - Output selection works in write mode only
// - Write clock divided by sixteen for step
//
// The AXI4-Lite slave port and the register addresses were left to the implementer.
`timescale 1ns/1ns
`include "scg_defines.svh"
module scg_top (
    input wire logic sys_clk, // 20 MHz system clock
    input wire logic nrst, // Async reset, active low
    input wire scg_pkg::scg_axil_req_type axil_req, // AXI4-Lite requests
    output scg_pkg::scg_axil_resp_type axil_resp, // AXI4-Lite answers
    input wire logic serial_in_n, // Serial data in, active low
    input wire logic bit_shift_clock, // Bit shift clock pin
    input wire logic byte_strobe_n, // Byte strobe, active low
    input wire logic data_or_crc_select, // High data, low checkword
    input wire logic crc_init_n, // Init strobe, active low
    input wire logic write_bit_clock, // Write clock to divide
    output logic serial_out_n, // Serial data out, active low
    output logic checkword_active_n, // Low while check bytes sent
    output logic skip_gate, // High until first input fall
    output logic check_pass, // Read check passed
    output logic check_pass_n, // Complement of check_pass
    output logic step_clock_out // Write clock over sixteen
);
    import scg_pkg::*;

    // ********************************
    // Function definitions
    // ********************************
    // One MSB-first step of the check register
    function automatic logic [`SCG_CRC_W-1:0] crc_step(
        input logic [`SCG_CRC_W-1:0] crc,
        input logic bit_in
    );
        logic fb;
        fb = crc[`SCG_CRC_W-1] ^ bit_in;
        crc_step = {crc[`SCG_CRC_W-2:0], 1'b0} ^ (fb ? `SCG_CRC_POLY : `SCG_CRC_ZERO);
    endfunction : crc_step

    // Word address decode
    function automatic logic addr_is(
        input logic [31:0] addr,
        input logic [`SCG_ADDR_W-1:0] off
    );
        addr_is = (addr[`SCG_ADDR_W-1:2] == off[`SCG_ADDR_W-1:2]);
    endfunction : addr_is

    // ********************************
    // Pin synchronisation
    // ********************************
    logic [`SCG_PIN_W-1:0] pins_s;
    logic [`SCG_PIN_W-1:0] pins_prev_q;

    scg_sync #(
        .W(`SCG_PIN_W),
        .RST_VAL(`SCG_PIN_RST)
    ) u_sync (
        .sys_clk(sys_clk),
        .nrst(nrst),
        .async_in({serial_in_n, bit_shift_clock, byte_strobe_n,
                   data_or_crc_select, crc_init_n, write_bit_clock}),
        .sync_out(pins_s)
    );

    // Previous synchronised levels for edge detection
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            pins_prev_q <= `SCG_PIN_RST;
        end else begin
            pins_prev_q <= pins_s;
        end
    end

    logic din_s;
    logic sel_s;
    logic init_n_s;
    logic din_fall;
    logic shf_fall;
    logic shf_rise;
    logic stb_fall;
    logic wck_rise;
    logic data_bit;

    assign din_s = pins_s[`SCG_PIN_DIN];
    assign sel_s = pins_s[`SCG_PIN_SEL];
    assign init_n_s = pins_s[`SCG_PIN_INI];
    assign din_fall = pins_prev_q[`SCG_PIN_DIN] & ~din_s;
    assign shf_fall = pins_prev_q[`SCG_PIN_SHF] & ~pins_s[`SCG_PIN_SHF];
    assign shf_rise = ~pins_prev_q[`SCG_PIN_SHF] & pins_s[`SCG_PIN_SHF];
    assign stb_fall = pins_prev_q[`SCG_PIN_STB] & ~pins_s[`SCG_PIN_STB];
    assign wck_rise = ~pins_prev_q[`SCG_PIN_WCK] & pins_s[`SCG_PIN_WCK];
    // Line is active low, so a low level carries a one
    assign data_bit = ~din_s;

    // ********************************
    // Register file
    // ********************************
    logic write_mode_q;
    logic aw_have_q;
    logic w_have_q;
    logic [31:0] awaddr_q;
    logic [31:0] wdata_q;
    logic [3:0] wstrb_q;
    logic bvalid_q;
    logic [1:0] bresp_q;
    logic rvalid_q;
    logic [31:0] rdata_q;
    logic [1:0] rresp_q;
    logic aw_take;
    logic w_take;
    logic ar_take;
    logic wr_go;

    assign aw_take = axil_req.awvalid & ~aw_have_q & ~bvalid_q;
    assign w_take = axil_req.wvalid & ~w_have_q & ~bvalid_q;
    assign ar_take = axil_req.arvalid & ~rvalid_q;
    assign wr_go = aw_have_q & w_have_q & ~bvalid_q;

    // Handshakes are combinational, payloads come from flops
    always_comb begin
        axil_resp.awready = ~aw_have_q & ~bvalid_q;
        axil_resp.wready = ~w_have_q & ~bvalid_q;
        axil_resp.bvalid = bvalid_q;
        axil_resp.bresp = bresp_q;
        axil_resp.arready = ~rvalid_q;
        axil_resp.rvalid = rvalid_q;
        axil_resp.rdata = rdata_q;
        axil_resp.rresp = rresp_q;
    end

    // Write channel: address and data taken in either order
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            aw_have_q <= 1'b0;
            w_have_q <= 1'b0;
            awaddr_q <= 32'h0000_0000;
            wdata_q <= 32'h0000_0000;
            wstrb_q <= 4'h0;
            bvalid_q <= 1'b0;
            bresp_q <= `SCG_RESP_OKAY;
        end else begin
            if (aw_take) begin
                aw_have_q <= 1'b1;
                awaddr_q <= axil_req.awaddr;
            end
            if (w_take) begin
                w_have_q <= 1'b1;
                wdata_q <= axil_req.wdata;
                wstrb_q <= axil_req.wstrb;
            end
            if (wr_go) begin
                aw_have_q <= 1'b0;
                w_have_q <= 1'b0;
                bvalid_q <= 1'b1;
                bresp_q <= (addr_is(awaddr_q, `SCG_ADDR_CTRL) ||
                             addr_is(awaddr_q, `SCG_ADDR_STATUS)) ?
                           `SCG_RESP_OKAY : `SCG_RESP_SLVERR;
            end else if (bvalid_q && axil_req.bready) begin
                bvalid_q <= 1'b0;
            end
        end
    end

    // Mode bit; status is read-only and ignores writes
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            write_mode_q <= 1'(`SCG_CTRL_RST);
        end else if (wr_go && addr_is(awaddr_q, `SCG_ADDR_CTRL) && wstrb_q[0]) begin
            write_mode_q <= wdata_q[`SCG_CTRL_WMODE];
        end
    end

    // ********************************
    // Check register and skip gate
    // ********************************
    logic skip_q;
    logic [`SCG_CRC_W-1:0] crc_q;
    logic [`SCG_CNT_W-1:0] cw_cnt_q;
    logic [`SCG_CNT_W-1:0] rd_cnt_q;
    logic sel_q;
    scg_out_state_type out_q;
    logic cw_shift;

    // Checkword bits leave the register rather than new data entering it
    assign cw_shift = write_mode_q & (out_q == OUT_CHECK);

    // Skip gate arms on init and drops on the first input fall
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            skip_q <= 1'b1;
        end else if (!init_n_s) begin
            skip_q <= 1'b1;
        end else if (din_fall) begin
            skip_q <= 1'b0;
        end
    end

    // Register shifts only once the skip gate has dropped
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            crc_q <= `SCG_CRC_PRESET;
        end else if (!init_n_s) begin
            crc_q <= `SCG_CRC_PRESET;
        end else if (shf_fall && !skip_q) begin
            if (cw_shift) begin
                crc_q <= {crc_q[`SCG_CRC_W-2:0], 1'b0};
            end else begin
                crc_q <= crc_step(crc_q, data_bit);
            end
        end
    end

    // Read side bit count, saturating at sixteen bits, the length of both check bytes
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            rd_cnt_q <= '0;
        end else if (!init_n_s) begin
            rd_cnt_q <= '0;
        end else if (shf_fall && !skip_q && rd_cnt_q < `SCG_CNT_W'(`SCG_CW_BITS)) begin
            rd_cnt_q <= rd_cnt_q + 1'b1;
        end
    end

    // ********************************
    // Write side output selection
    // ********************************
    // Select flop; strobes are ignored in read mode
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            sel_q <= 1'b1;
        end else if (stb_fall && write_mode_q) begin
            sel_q <= sel_s;
        end
    end

    // Output path state and checkword bit count
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            out_q <= OUT_DATA;
            cw_cnt_q <= '0;
        end else begin
            case (out_q)
                OUT_DATA: begin
                    cw_cnt_q <= '0;
                    if (write_mode_q && !sel_q) begin
                        out_q <= OUT_CHECK;
                    end
                end
                OUT_CHECK: begin
                    if (sel_q || !write_mode_q) begin
                        out_q <= OUT_DATA;
                    end else if (shf_fall && !skip_q) begin
                        cw_cnt_q <= cw_cnt_q + 1'b1;
                        if (cw_cnt_q == `SCG_CNT_W'(`SCG_CW_BITS - 1)) begin
                            out_q <= OUT_TAIL;
                        end
                    end
                end
                OUT_TAIL: begin
                    if (sel_q || !write_mode_q) begin
                        out_q <= OUT_DATA;
                    end
                end
                default: begin
                    out_q <= OUT_DATA;
                end
            endcase
        end
    end

    // Serial output; dormant high in read mode
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            serial_out_n <= 1'b1;
        end else if (!write_mode_q) begin
            serial_out_n <= 1'b1;
        end else if (out_q == OUT_DATA) begin
            serial_out_n <= din_s;
        end else if (shf_fall && !skip_q) begin
            // Last check bit stands a full bit time before the line idles high
            serial_out_n <= (out_q == OUT_TAIL) ? 1'b1 : ~crc_q[`SCG_CRC_W-1];
        end
    end

    // Checkword flag follows the output path
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            checkword_active_n <= 1'b1;
        end else begin
            checkword_active_n <= ~(write_mode_q && out_q == OUT_CHECK);
        end
    end

    assign skip_gate = skip_q;

    // ********************************
    // Read side pass outputs
    // ********************************
    logic pass_hit;

    // Zero residue after both check bytes, sampled on the shift rise
    assign pass_hit = !write_mode_q && !skip_q && shf_rise &&
                      rd_cnt_q == `SCG_CNT_W'(`SCG_CW_BITS) && crc_q == `SCG_CRC_ZERO;

    // Set wins over the clear from a low input level
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            check_pass <= 1'b0;
            check_pass_n <= 1'b1;
        end else if (!init_n_s) begin
            check_pass <= 1'b0;
            check_pass_n <= 1'b1;
        end else if (pass_hit) begin
            check_pass <= 1'b1;
            check_pass_n <= 1'b0;
        end else if (!din_s) begin
            check_pass <= 1'b0;
            check_pass_n <= 1'b1;
        end
    end

    // ********************************
    // Step clock divider
    // ********************************
    logic [`SCG_STEP_W-1:0] step_cnt_q;

    // Nothing else sees the write clock
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            step_cnt_q <= '0;
            step_clock_out <= 1'b0;
        end else if (wck_rise) begin
            step_cnt_q <= step_cnt_q + 1'b1;
            step_clock_out <= (step_cnt_q == `SCG_STEP_W'(`SCG_STEP_DIV / 2 - 1)) ?
                              ~step_clock_out :
                              (step_cnt_q == `SCG_STEP_W'(`SCG_STEP_DIV - 1)) ?
                              ~step_clock_out : step_clock_out;
        end
    end

    // ********************************
    // Read data
    // ********************************
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            rvalid_q <= 1'b0;
            rdata_q <= 32'h0000_0000;
            rresp_q <= `SCG_RESP_OKAY;
        end else if (ar_take) begin
            rvalid_q <= 1'b1;
            rresp_q <= `SCG_RESP_OKAY;
            rdata_q <= 32'h0000_0000;
            if (addr_is(axil_req.araddr, `SCG_ADDR_CTRL)) begin
                rdata_q[`SCG_CTRL_WMODE] <= write_mode_q;
            end else if (addr_is(axil_req.araddr, `SCG_ADDR_STATUS)) begin
                rdata_q[`SCG_ST_PASS] <= check_pass;
                rdata_q[`SCG_ST_SKIP] <= skip_q;
                rdata_q[`SCG_ST_CWACT] <= ~checkword_active_n;
                rdata_q[`SCG_ST_SEL] <= sel_q;
                rdata_q[`SCG_ST_CRC_LSB +: `SCG_CRC_W] <= crc_q;
            end else begin
                rresp_q <= `SCG_RESP_SLVERR;
            end
        end else if (rvalid_q && axil_req.rready) begin
            rvalid_q <= 1'b0;
        end
    end

    // ********************************
    // Assertions
    // ********************************
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!nrst);

    sequence s_init_pulse;
        !init_n_s ##1 init_n_s;
    endsequence

    sequence s_data_shift;
        shf_fall && !skip_q && !cw_shift && init_n_s;
    endsequence

    AST_INIT_PRESET: assert property (s_init_pulse |-> skip_q && crc_q == `SCG_CRC_PRESET)
        else $error("init did not preset register and skip gate");

    AST_SKIP_RELEASE: assert property (skip_q && init_n_s && din_fall |=> !skip_q)
        else $error("skip gate did not drop on first input fall");

    AST_CRC_STEP: assert property (
        s_data_shift |=> crc_q == crc_step($past(crc_q), $past(data_bit)))
        else $error("check register step wrong");

    AST_SEL_CAPTURE: assert property (stb_fall && write_mode_q |=> sel_q == $past(sel_s))
        else $error("select flop missed strobe");

    AST_CW_FLAG: assert property (
        write_mode_q && out_q == OUT_CHECK ##1 write_mode_q && out_q == OUT_CHECK
        |-> !checkword_active_n)
        else $error("checkword flag not low during check bytes");

    AST_TAIL_HIGH: assert property (
        write_mode_q && out_q == OUT_TAIL && shf_fall && !skip_q |=> serial_out_n [*2])
        else $error("output not high after check bytes");

    AST_CHECK_LEN: assert property (
        out_q == OUT_CHECK && cw_cnt_q == `SCG_CNT_W'(`SCG_CW_BITS - 1) && shf_fall && !skip_q
        && write_mode_q && !sel_q |=> out_q == OUT_TAIL)
        else $error("check bytes not sixteen bits");

    AST_PASS_COMPL: assert property (check_pass_n == !check_pass)
        else $error("pass outputs not complementary");

    AST_PASS_SET: assert property (pass_hit && init_n_s |=> check_pass && !check_pass_n)
        else $error("pass not set on zero residue");

    AST_PASS_HOLD: assert property (check_pass && din_s && init_n_s |=> check_pass)
        else $error("pass dropped while input high");

    AST_READ_DORMANT: assert property (
        !write_mode_q ##1 !write_mode_q |-> serial_out_n && checkword_active_n)
        else $error("write path active in read mode");

    AST_STEP_DIV: assert property (
        wck_rise && step_cnt_q == `SCG_STEP_W'(`SCG_STEP_DIV - 1)
        |=> step_clock_out != $past(step_clock_out))
        else $error("step clock did not toggle");

endmodule : scg_top

/* rtl/scg_defines.svh */
`ifndef SCG_DEFINES_SVH
`define SCG_DEFINES_SVH

// Clock rate
`define SCG_CLK_HZ 20_000_000
`define SCG_CLK_NS 50

// Check register
`define SCG_CRC_W 16
`define SCG_CRC_POLY 16'h1021
`define SCG_CRC_PRESET 16'hFFFF
`define SCG_CRC_ZERO 16'h0000

// Byte framing: two check bytes of eight bits each
`define SCG_BYTE_BITS 8
`define SCG_CW_BYTES 2
`define SCG_CW_BITS 16
`define SCG_CNT_W 5

// Step clock divider
`define SCG_STEP_DIV 16
`define SCG_STEP_W 4

// Pin synchroniser layout and idle levels
`define SCG_PIN_W 6
`define SCG_PIN_DIN 5
`define SCG_PIN_SHF 4
`define SCG_PIN_STB 3
`define SCG_PIN_SEL 2
`define SCG_PIN_INI 1
`define SCG_PIN_WCK 0
`define SCG_PIN_RST 6'h3E

// Register map, byte addresses
`define SCG_ADDR_W 8
`define SCG_ADDR_CTRL 8'h00
`define SCG_ADDR_STATUS 8'h04
`define SCG_CTRL_RST 32'h0000_0000
`define SCG_CTRL_WMODE 0
`define SCG_ST_PASS 0
`define SCG_ST_SKIP 1
`define SCG_ST_CWACT 2
`define SCG_ST_SEL 3
`define SCG_ST_CRC_LSB 16

// AXI responses
`define SCG_RESP_OKAY 2'h0
`define SCG_RESP_SLVERR 2'h2

`endif

/* rtl/scg_pkg.sv */
package scg_pkg;

    // Output path of the write side
    typedef enum logic [2:0] {
        OUT_DATA = 3'b001,
        OUT_CHECK = 3'b010,
        OUT_TAIL = 3'b100
    } scg_out_state_type;

    // AXI4-Lite master to slave
    typedef struct packed {
        logic awvalid;
        logic [31:0] awaddr;
        logic wvalid;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic bready;
        logic arvalid;
        logic [31:0] araddr;
        logic rready;
    } scg_axil_req_type;

    // AXI4-Lite slave to master
    typedef struct packed {
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } scg_axil_resp_type;

endpackage : scg_pkg

/* rtl/scg_sync.sv */
`timescale 1ns/1ns
module scg_sync #(
    parameter int W = 1,
    parameter logic [W-1:0] RST_VAL = '0
) (
    input wire logic sys_clk, // System clock
    input wire logic nrst, // Async reset, active low
    input wire logic [W-1:0] async_in, // Pins from outside
    output logic [W-1:0] sync_out // Synchronised levels
);
    logic [W-1:0] meta_q;

    // ********************************
    // Two-stage synchroniser
    // ********************************
    // First stage feeds only the second, to contain metastability
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            meta_q <= RST_VAL;
            sync_out <= RST_VAL;
        end else begin
            meta_q <= async_in;
            sync_out <= meta_q;
        end
    end
endmodule : scg_sync

/* tb/scg_ctl_model.sv */
`timescale 1ns/1ns
module scg_ctl_model (
    input wire logic sys_clk, // System clock
    output logic serial_in_n, // Serial data, active low
    output logic bit_shift_clock, // Shift clock, idle high
    output logic byte_strobe_n, // Byte strobe, active low
    output logic data_or_crc_select, // High data, low checkword
    output logic crc_init_n, // Init, active low
    output logic write_bit_clock // Clock to be divided
);
    logic wclk_run = 1'b0;

    // ********
    // Pin sequencing
    // ********
    task automatic wait_clk(input int n);
        repeat (n) @(posedge sys_clk);
    endtask : wait_clk

    // Init pulse comes before any frame
    task automatic init_pulse();
        crc_init_n <= 1'b0;
        wait_clk(4);
        crc_init_n <= 1'b1;
        wait_clk(4);
    endtask : init_pulse

    // Data set up well before the fall, since pins pass a synchroniser
    task automatic put_bit(input logic b);
        serial_in_n <= ~b;
        wait_clk(4);
        bit_shift_clock <= 1'b0;
        wait_clk(4);
        bit_shift_clock <= 1'b1;
        wait_clk(6);
    endtask : put_bit

    task automatic put_byte(input logic [7:0] v);
        for (int i = 7; i >= 0; i--) put_bit(v[i]);
    endtask : put_byte

    // Select settles ahead of the strobe fall
    task automatic strobe(input logic sel);
        data_or_crc_select <= sel;
        wait_clk(4);
        byte_strobe_n <= 1'b0;
        wait_clk(4);
        byte_strobe_n <= 1'b1;
        wait_clk(4);
    endtask : strobe

    // Idle levels, then a write clock that stands still unless asked
    initial begin
        serial_in_n = 1'b1;
        bit_shift_clock = 1'b1;
        byte_strobe_n = 1'b1;
        data_or_crc_select = 1'b1;
        crc_init_n = 1'b1;
        write_bit_clock = 1'b0;
        forever begin
            wait_clk(4);
            if (wclk_run) write_bit_clock <= ~write_bit_clock;
        end
    end
endmodule : scg_ctl_model

/* tb/test_serial_crc16_generator_checker.sv */
`timescale 1ns/1ns
module test_serial_crc16_generator_checker;
    import scg_pkg::*;
    logic sys_clk, nrst, serial_in_n, bit_shift_clock, byte_strobe_n, data_or_crc_select;
    logic crc_init_n, write_bit_clock, serial_out_n, checkword_active_n, skip_gate;
    logic check_pass, check_pass_n, step_clock_out;
    scg_axil_req_type req;
    scg_axil_resp_type rsp;
    int errors = 0;
    int tests_run = 0;
    logic [15:0] crc_exp;
    logic [31:0] rd;
    logic [1:0] rs;

    scg_top uut (.sys_clk(sys_clk), .nrst(nrst), .axil_req(req), .axil_resp(rsp),
        .serial_in_n(serial_in_n), .bit_shift_clock(bit_shift_clock),
        .byte_strobe_n(byte_strobe_n), .data_or_crc_select(data_or_crc_select),
        .crc_init_n(crc_init_n), .write_bit_clock(write_bit_clock),
        .serial_out_n(serial_out_n), .checkword_active_n(checkword_active_n),
        .skip_gate(skip_gate), .check_pass(check_pass), .check_pass_n(check_pass_n),
        .step_clock_out(step_clock_out));
    scg_ctl_model ctl (.sys_clk(sys_clk), .serial_in_n(serial_in_n),
        .bit_shift_clock(bit_shift_clock), .byte_strobe_n(byte_strobe_n),
        .data_or_crc_select(data_or_crc_select), .crc_init_n(crc_init_n),
        .write_bit_clock(write_bit_clock));

    // ********
    // Checking helpers
    // ********
    initial begin
        sys_clk = 1'b0;
        forever #25 sys_clk = ~sys_clk;
    end

    task automatic chk_bit(input logic got, input logic exp, input string what);
        tests_run++;
        if (got !== exp) begin
            errors++;
            $display("ERROR %0t %s got %b exp %b", $time, what, got, exp);
        end
    endtask : chk_bit

    task automatic chk_word(input logic [31:0] got, input logic [31:0] exp, input string what);
        tests_run++;
        if (got !== exp) begin
            errors++;
            $display("ERROR %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask : chk_word

    // Reference check word, MSB first
    task automatic crc_byte(input logic [7:0] v);
        for (int i = 7; i >= 0; i--) begin
            crc_exp = {crc_exp[14:0], 1'b0} ^ ((crc_exp[15] ^ v[i]) ? 16'h1021 : 16'h0000);
        end
    endtask : crc_byte

    // Bus master: holds each channel until its own ready
    task automatic axi_wr(input logic [31:0] a, input logic [31:0] d, output logic [1:0] r,
                          input logic [3:0] s = 4'hF);
        @(posedge sys_clk);
        req.awvalid <= 1'b1;
        req.awaddr <= a;
        req.wvalid <= 1'b1;
        req.wdata <= d;
        req.wstrb <= s;
        req.bready <= 1'b1;
        r = 2'b11;
        forever begin
            @(posedge sys_clk);
            if (rsp.awready) req.awvalid <= 1'b0;
            if (rsp.wready) req.wvalid <= 1'b0;
            if (rsp.bvalid) begin
                r = rsp.bresp;
                req.bready <= 1'b0;
                break;
            end
        end
    endtask : axi_wr

    task automatic axi_rd(input logic [31:0] a, output logic [31:0] d, output logic [1:0] r);
        @(posedge sys_clk);
        req.arvalid <= 1'b1;
        req.araddr <= a;
        req.rready <= 1'b1;
        r = 2'b11;
        d = 32'hDEAD_BEEF;
        forever begin
            @(posedge sys_clk);
            if (rsp.arready) req.arvalid <= 1'b0;
            if (rsp.rvalid) begin
                d = rsp.rdata;
                r = rsp.rresp;
                req.rready <= 1'b0;
                break;
            end
        end
    endtask : axi_rd

    // ********
    // Scenarios
    // ********
    task automatic t_regs();
        axi_rd(32'h0000_0000, rd, rs);
        chk_word(rd, 32'h0000_0000, "ctrl reset");
        axi_rd(32'h0000_0004, rd, rs);
        chk_word(rd, 32'hFFFF_000A, "status reset");
        axi_wr(32'h0000_0008, 32'h0000_0001, rs);
        chk_word({30'h0, rs}, 32'h0000_0002, "unmapped write");
        axi_rd(32'h0000_0008, rd, rs);
        chk_word({30'h0, rs}, 32'h0000_0002, "unmapped read");
        axi_wr(32'h0000_0004, 32'h0000_0000, rs);
        axi_rd(32'h0000_0004, rd, rs);
        chk_word(rd, 32'hFFFF_000A, "status read only");
        axi_wr(32'h0000_0000, 32'h0000_0001, rs, 4'h0);
        axi_rd(32'h0000_0000, rd, rs);
        chk_word(rd, 32'h0000_0000, "ctrl no strobe");
        $display("register test done");
    endtask : t_regs

    task automatic t_write();
        logic [15:0] dat;
        dat = 16'hA15C;
        crc_exp = 16'hFFFF;
        crc_byte(dat[15:8]);
        crc_byte(dat[7:0]);
        axi_wr(32'h0000_0000, 32'h0000_0001, rs);
        ctl.init_pulse();
        chk_bit(skip_gate, 1'b1, "skip in init");
        ctl.strobe(1'b1);
        ctl.put_bit(1'b0);
        ctl.put_bit(1'b0);
        chk_bit(skip_gate, 1'b1, "skip before mark");
        for (int i = 15; i >= 0; i--) begin
            ctl.put_bit(dat[i]);
            chk_bit(serial_out_n, ~dat[i], "pass data");
            chk_bit(checkword_active_n, 1'b1, "flag in data");
            if (i == 15) chk_bit(skip_gate, 1'b0, "skip after mark");
            if (i == 8) ctl.strobe(1'b1);
        end
        ctl.strobe(1'b0);
        for (int i = 15; i >= 0; i--) begin
            ctl.put_bit(1'b0);
            chk_bit(serial_out_n, ~crc_exp[i], "check bit");
            if (i > 0) chk_bit(checkword_active_n, 1'b0, "flag in check");
        end
        ctl.put_bit(1'b0);
        ctl.put_bit(1'b0);
        chk_bit(serial_out_n, 1'b1, "tail");
        chk_bit(checkword_active_n, 1'b1, "flag after");
        $display("write test done");
    endtask : t_write

    task automatic t_read(input logic bad);
        crc_exp = 16'hFFFF;
        crc_byte(8'hA1);
        // Data picked so the last check bit leaves the input line high
        crc_byte(8'h5D);
        axi_wr(32'h0000_0000, 32'h0000_0000, rs);
        ctl.init_pulse();
        chk_bit(check_pass, 1'b0, "pass after init");
        ctl.put_byte(8'hA1);
        ctl.strobe(1'b0);
        ctl.put_byte(8'h5D);
        chk_bit(checkword_active_n, 1'b1, "select in read");
        ctl.put_byte(crc_exp[15:8] ^ {7'h00, bad});
        ctl.put_byte(crc_exp[7:0]);
        chk_bit(check_pass, ~bad, "pass");
        chk_bit(check_pass_n, bad, "pass inverse");
        if (!bad) begin
            ctl.wait_clk(40);
            ctl.put_bit(1'b0);
            chk_bit(check_pass, 1'b1, "pass held");
            chk_bit(check_pass_n, 1'b0, "inverse held");
        end
        $display("read test done");
    endtask : t_read

    task automatic t_step();
        int cnt;
        int flips;
        logic pw;
        logic ps;
        cnt = 0;
        flips = 0;
        pw = write_bit_clock;
        ps = step_clock_out;
        ctl.wclk_run <= 1'b1;
        for (int i = 0; i < 800 && flips < 3; i++) begin
            @(posedge sys_clk);
            if (write_bit_clock && !pw) cnt++;
            if (step_clock_out !== ps) begin
                if (flips > 0) chk_word(cnt, 32'h0000_0008, "step half");
                flips++;
                cnt = 0;
            end
            pw = write_bit_clock;
            ps = step_clock_out;
        end
        chk_word(flips, 32'h0000_0003, "step flips");
        ctl.wclk_run <= 1'b0;
        $display("step test done");
    endtask : t_step

    task automatic results();
        $display("Checks %0d mismatches %0d", tests_run, errors);
        if (errors == 0 && tests_run > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : results

    initial begin
        req = '0;
        nrst = 1'b0;
        repeat (10) @(posedge sys_clk);
        nrst <= 1'b1;
        @(posedge sys_clk);
        t_regs();
        t_write();
        t_read(1'b0);
        t_read(1'b1);
        t_step();
        results();
    end

    // Runs take some 1800 cycles; this cuts a hang short
    initial begin
        repeat (30000) @(posedge sys_clk);
        errors++;
        $display("ERROR %0t watchdog expired", $time);
        results();
    end
endmodule : test_serial_crc16_generator_checker
